//--- hdl/ldr_top.sv
// Drive range, step-up factor and sleep/standby control of the LCD driver
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps

// Contract
// - The boost factor select field 00, 01, 10, 11 picks four, five, six, seven times.
// - Single screen time-shares commons start+1 to end+1, others non-selection.
// - Two screens time-share both ranges, all remaining commons non-selection.
// - Ranges shorter than the duty leave lines outside them at non-selection.
// - Ranges longer than the duty show lines from the start up to the duty line only.
// - In single screen the second range fields are ignored.
// - Sleep halts display and sync outputs, keeps the oscillator, grounds all outputs.
// - With drive amp power 00 in sleep or standby the LCD drive supply is off.
// - Standby stops the oscillator, sync outputs and grounds the driver outputs.
// - In standby every instruction other than start-oscillation is rejected; the code also accepts the power word once the oscillator runs.
module ldr_top #(
   parameter int OSC_DIV = ldr_pkg::OSC_DIV,
   parameter int TICKS_PER_LINE = ldr_pkg::LINE_OSC_TICKS,
   parameter int LINES = ldr_pkg::NUM_LINES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [ldr_pkg::ADDR_W-1:0] regAddr,
   input wire logic [ldr_pkg::DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [ldr_pkg::DATA_W-1:0] regRdata,
   output logic [LINES-1:0] comTimeShare,
   output logic [ldr_pkg::LINE_W-1:0] activeLine,
   output logic outputsGround,
   output logic [2:0] boostMult,
   output logic [1:0] boost_factor_sel,
   output logic lcdPowerEn,
   output logic oscRunning,
   output logic frame_start_sync,
   output logic line_latch_sync,
   output logic shift_clock_sync
);

   // ************************************************************
   // Reset release
   // ************************************************************
   logic rstMeta_r;
   logic rstSync_r;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [ldr_pkg::LINE_W-1:0] start1;
      logic [ldr_pkg::LINE_W-1:0] end1;
      logic [ldr_pkg::LINE_W-1:0] start2;
      logic [ldr_pkg::LINE_W-1:0] end2;
      logic twoScreen;
      logic sleep;
      logic standby;
      logic [1:0] amp;
      logic [1:0] boost;
      logic [ldr_pkg::DUTY_W-1:0] duty;
      logic oscOn;
      logic [15:0] oscCnt;
      logic oscTick;
      logic [LINES-1:0] comSel;
      logic ground;
      logic lcdPwr;
      logic [2:0] mult;
      logic [ldr_pkg::DATA_W-1:0] rdata;
   } ldr_top_s;

   ldr_top_s state_r;
   ldr_top_s state_nxt;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [2:0] boostToMult(input logic [1:0] sel);
      logic [2:0] m;
      m = ldr_pkg::MULT_X4;
      unique case (ldr_pkg::ldr_boost_e'(sel))
         ldr_pkg::BOOST_X4: m = ldr_pkg::MULT_X4;
         ldr_pkg::BOOST_X5: m = ldr_pkg::MULT_X5;
         ldr_pkg::BOOST_X6: m = ldr_pkg::MULT_X6;
         ldr_pkg::BOOST_X7: m = ldr_pkg::MULT_X7;
      endcase
      return m;
   endfunction

   function automatic logic [ldr_pkg::DATA_W-1:0] packRange(
      input logic [ldr_pkg::LINE_W-1:0] s, input logic [ldr_pkg::LINE_W-1:0] e);
      logic [ldr_pkg::DATA_W-1:0] w;
      w = '0;
      w[ldr_pkg::RNG_START_LSB +: ldr_pkg::LINE_W] = s;
      w[ldr_pkg::RNG_END_LSB +: ldr_pkg::LINE_W] = e;
      return w;
   endfunction

   // ************************************************************
   // Derived values
   // ************************************************************
   logic [7:0] dutyLines;
   logic displayOn;
   logic [LINES-1:0] rangeMask;
   logic [ldr_pkg::LINE_W-1:0] scanLine;
   logic scanFrame;
   logic scanLatch;
   logic scanShift;
   logic writeOk;

   assign dutyLines = 8'(({4'h0, state_r.duty} + 8'h01) * 8'(ldr_pkg::DUTY_STEP));
   assign displayOn = state_r.oscOn && !state_r.sleep && !state_r.standby;

   // Standby accepts start-oscillation; once it runs, the power word may clear standby
   assign writeOk = !state_r.standby
                    || (regAddr == ldr_pkg::IDX_OSC_START)
                    || (state_r.oscOn && regAddr == ldr_pkg::IDX_POWER);

   ldr_range_map #(
      .LINES(LINES)
   ) uMap (
      .start1(state_r.start1),
      .end1(state_r.end1),
      .start2(state_r.start2),
      .end2(state_r.end2),
      .twoScreen(state_r.twoScreen),
      .dutyLines(dutyLines),
      .lineMask(rangeMask)
   );

   ldr_line_scan #(
      .TICKS_PER_LINE(TICKS_PER_LINE)
   ) uScan (
      .core_clk(core_clk),
      .rst_n(rstSync_r),
      .run(displayOn),
      .oscTick(state_r.oscTick),
      .dutyLines(dutyLines),
      .lineIdx(scanLine),
      .frameSync(scanFrame),
      .latchSync(scanLatch),
      .shiftSync(scanShift)
   );

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      state_nxt = state_r;
      state_nxt.oscTick = 1'b0;
      state_nxt.rdata = '0;

      // Internal R-C oscillator, modelled as a divided core clock
      if (state_r.oscOn) begin
         if (state_r.oscCnt == 16'(OSC_DIV - 1)) begin
            state_nxt.oscCnt = 16'h0000;
            state_nxt.oscTick = 1'b1;
         end else begin
            state_nxt.oscCnt = state_r.oscCnt + 16'h0001;
         end
      end else begin
         state_nxt.oscCnt = 16'h0000;
      end

      if (regWr && writeOk) begin
         unique case (regAddr)
            ldr_pkg::IDX_RANGE1: begin
               state_nxt.start1 = regWdata[ldr_pkg::RNG_START_LSB +: ldr_pkg::LINE_W];
               state_nxt.end1 = regWdata[ldr_pkg::RNG_END_LSB +: ldr_pkg::LINE_W];
            end
            ldr_pkg::IDX_RANGE2: begin
               state_nxt.start2 = regWdata[ldr_pkg::RNG_START_LSB +: ldr_pkg::LINE_W];
               state_nxt.end2 = regWdata[ldr_pkg::RNG_END_LSB +: ldr_pkg::LINE_W];
            end
            ldr_pkg::IDX_POWER: begin
               state_nxt.standby = regWdata[ldr_pkg::PWR_STANDBY];
               state_nxt.sleep = regWdata[ldr_pkg::PWR_SLEEP];
               state_nxt.amp = regWdata[ldr_pkg::PWR_AMP_LSB +: 2];
               state_nxt.boost = regWdata[ldr_pkg::PWR_BOOST_LSB +: 2];
               state_nxt.twoScreen = regWdata[ldr_pkg::PWR_TWO_SCREEN];
               state_nxt.duty = regWdata[ldr_pkg::PWR_DUTY_LSB +: ldr_pkg::DUTY_W];
               if (regWdata[ldr_pkg::PWR_STANDBY]) begin
                  state_nxt.oscOn = 1'b0;
               end
            end
            ldr_pkg::IDX_OSC_START: begin
               state_nxt.oscOn = 1'b1;
            end
            default: begin
            end
         endcase
      end

      if (regRd) begin
         unique case (regAddr)
            ldr_pkg::IDX_RANGE1: state_nxt.rdata = packRange(state_r.start1, state_r.end1);
            ldr_pkg::IDX_RANGE2: state_nxt.rdata = packRange(state_r.start2, state_r.end2);
            ldr_pkg::IDX_POWER: begin
               state_nxt.rdata[ldr_pkg::PWR_STANDBY] = state_r.standby;
               state_nxt.rdata[ldr_pkg::PWR_SLEEP] = state_r.sleep;
               state_nxt.rdata[ldr_pkg::PWR_AMP_LSB +: 2] = state_r.amp;
               state_nxt.rdata[ldr_pkg::PWR_BOOST_LSB +: 2] = state_r.boost;
               state_nxt.rdata[ldr_pkg::PWR_TWO_SCREEN] = state_r.twoScreen;
               state_nxt.rdata[ldr_pkg::PWR_DUTY_LSB +: ldr_pkg::DUTY_W] = state_r.duty;
            end
            ldr_pkg::IDX_STATUS: begin
               state_nxt.rdata[ldr_pkg::ST_OSC] = state_r.oscOn;
               state_nxt.rdata[ldr_pkg::ST_DISPLAY] = displayOn;
               state_nxt.rdata[ldr_pkg::ST_LCD_PWR] = state_r.lcdPwr;
               state_nxt.rdata[ldr_pkg::ST_SYNC] = displayOn;
               state_nxt.rdata[ldr_pkg::ST_LINE_LSB +: ldr_pkg::LINE_W] = scanLine;
            end
            default: state_nxt.rdata = '0;
         endcase
      end

      // Driver outputs grounded whenever the display is halted
      state_nxt.comSel = displayOn ? rangeMask : '0;
      state_nxt.ground = !displayOn;
      state_nxt.lcdPwr = !((state_r.sleep || state_r.standby)
                           && state_r.amp == ldr_pkg::AMP_OFF);
      state_nxt.mult = boostToMult(state_r.boost);
   end

   always_ff @(posedge core_clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         state_r <= '0;
         state_r.start1 <= ldr_pkg::RST_START;
         state_r.end1 <= ldr_pkg::RST_END;
         state_r.start2 <= ldr_pkg::RST_START;
         state_r.end2 <= ldr_pkg::RST_START;
         state_r.duty <= ldr_pkg::RST_DUTY;
         state_r.amp <= ldr_pkg::RST_AMP;
         state_r.boost <= ldr_pkg::RST_BOOST;
         state_r.oscOn <= 1'b1;
         state_r.ground <= 1'b1;
         state_r.lcdPwr <= 1'b1;
         state_r.mult <= ldr_pkg::MULT_X4;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign regRdata = state_r.rdata;
   assign comTimeShare = state_r.comSel;
   assign activeLine = scanLine;
   assign outputsGround = state_r.ground;
   assign boostMult = state_r.mult;
   assign boost_factor_sel = state_r.boost;
   assign lcdPowerEn = state_r.lcdPwr;
   assign oscRunning = state_r.oscOn;
   assign frame_start_sync = scanFrame;
   assign line_latch_sync = scanLatch;
   assign shift_clock_sync = scanShift;

endmodule

//--- hdl/ldr_pkg.sv
// Constants and types shared by the drive range and power mode block
package ldr_pkg;

   // ************************************************************
   // Geometry and timing
   // ************************************************************
   localparam int NUM_LINES = 80;
   localparam int LINE_W = 7;
   localparam logic [LINE_W-1:0] MAX_LINE = 7'h4f;
   localparam int CORE_FREQ_KHZ = 200000;
   localparam int OSC_FREQ_KHZ = 180;
   localparam int OSC_DIV = CORE_FREQ_KHZ / OSC_FREQ_KHZ;
   localparam int LINE_OSC_TICKS = 16;
   localparam int DUTY_STEP = 8;

   // ************************************************************
   // Register indices on the command port
   // ************************************************************
   localparam int ADDR_W = 3;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] IDX_RANGE1 = 3'h0;
   localparam logic [ADDR_W-1:0] IDX_RANGE2 = 3'h1;
   localparam logic [ADDR_W-1:0] IDX_POWER = 3'h2;
   localparam logic [ADDR_W-1:0] IDX_OSC_START = 3'h3;
   localparam logic [ADDR_W-1:0] IDX_STATUS = 3'h4;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int RNG_START_LSB = 0;
   localparam int RNG_END_LSB = 8;
   localparam int PWR_STANDBY = 0;
   localparam int PWR_SLEEP = 1;
   localparam int PWR_AMP_LSB = 2;
   localparam int PWR_BOOST_LSB = 4;
   localparam int PWR_TWO_SCREEN = 6;
   localparam int PWR_DUTY_LSB = 8;
   localparam int DUTY_W = 4;
   localparam int ST_OSC = 0;
   localparam int ST_DISPLAY = 1;
   localparam int ST_LCD_PWR = 2;
   localparam int ST_SYNC = 3;
   localparam int ST_LINE_LSB = 4;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [LINE_W-1:0] RST_START = 7'h00;
   localparam logic [LINE_W-1:0] RST_END = 7'h4f;
   localparam logic [DUTY_W-1:0] RST_DUTY = 4'h9;
   localparam logic [1:0] RST_AMP = 2'h0;
   localparam logic [1:0] RST_BOOST = 2'h0;

   // ************************************************************
   // Encodings
   // ************************************************************
   localparam logic [1:0] AMP_OFF = 2'h0;
   typedef enum logic [1:0] {
      BOOST_X4 = 2'b00,
      BOOST_X5 = 2'b01,
      BOOST_X6 = 2'b10,
      BOOST_X7 = 2'b11
   } ldr_boost_e;
   localparam logic [2:0] MULT_X4 = 3'h4;
   localparam logic [2:0] MULT_X5 = 3'h5;
   localparam logic [2:0] MULT_X6 = 3'h6;
   localparam logic [2:0] MULT_X7 = 3'h7;

endpackage

//--- hdl/ldr_range_map.sv
// Maps the two screen ranges and duty setting onto a per-line time-share mask
`timescale 1ns/1ps
module ldr_range_map #(
   parameter int LINES = ldr_pkg::NUM_LINES
) (
   input wire logic [ldr_pkg::LINE_W-1:0] start1,
   input wire logic [ldr_pkg::LINE_W-1:0] end1,
   input wire logic [ldr_pkg::LINE_W-1:0] start2,
   input wire logic [ldr_pkg::LINE_W-1:0] end2,
   input wire logic twoScreen,
   input wire logic [7:0] dutyLines,
   output logic [LINES-1:0] lineMask
);

   function automatic logic inRange(input logic [7:0] idx, input logic [7:0] lo,
                                    input logic [7:0] hi);
      inRange = (idx >= lo) && (idx <= hi);
   endfunction

   logic [7:0] s1;
   logic [7:0] e1;
   logic [7:0] s2;
   logic [7:0] e2;
   logic [7:0] firstCount;

   assign s1 = {1'b0, start1};
   assign e1 = {1'b0, end1};
   assign s2 = {1'b0, start2};
   assign e2 = {1'b0, end2};
   assign firstCount = 8'(e1 - s1 + 8'h01);

   // Rank counts displayed lines from the first start line; beyond duty, non-selection
   always_comb begin
      logic [7:0] idx;
      logic [7:0] rank;
      logic hit;
      idx = 8'h00;
      rank = 8'h00;
      hit = 1'b0;
      for (int i = 0; i < LINES; i++) begin
         idx = 8'(i);
         hit = 1'b0;
         rank = 8'h00;
         if (inRange(idx, s1, e1)) begin
            hit = 1'b1;
            rank = 8'(idx - s1);
         end else if (twoScreen && inRange(idx, s2, e2)) begin
            hit = 1'b1;
            rank = 8'(firstCount + idx - s2);
         end
         lineMask[i] = hit && (rank < dutyLines);
      end
   end

endmodule

//--- hdl/ldr_line_scan.sv
// Line scanner producing the frame, line latch and shift clock sync signals
`timescale 1ns/1ps
module ldr_line_scan #(
   parameter int TICKS_PER_LINE = ldr_pkg::LINE_OSC_TICKS
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic oscTick,
   input wire logic [7:0] dutyLines,
   output logic [ldr_pkg::LINE_W-1:0] lineIdx,
   output logic frameSync,
   output logic latchSync,
   output logic shiftSync
);

   typedef struct packed {
      logic [7:0] sub;
      logic [ldr_pkg::LINE_W-1:0] line;
      logic frame;
      logic latch;
      logic shift;
   } ldr_scan_s;

   ldr_scan_s state_r;
   ldr_scan_s state_nxt;

   always_comb begin
      state_nxt = state_r;
      state_nxt.latch = 1'b0;
      if (!run) begin
         state_nxt = '0;
      end else if (oscTick) begin
         state_nxt.shift = !state_r.shift;
         if (state_r.sub == 8'(TICKS_PER_LINE - 1)) begin
            state_nxt.sub = 8'h00;
            state_nxt.latch = 1'b1;
            if ({1'b0, state_r.line} >= 8'(dutyLines - 8'h01)) begin
               state_nxt.line = '0;
            end else begin
               state_nxt.line = state_r.line + 7'h01;
            end
            state_nxt.frame = (state_nxt.line == '0);
         end else begin
            state_nxt.sub = state_r.sub + 8'h01;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign lineIdx = state_r.line;
   assign frameSync = state_r.frame;
   assign latchSync = state_r.latch;
   assign shiftSync = state_r.shift;

endmodule

//--- tb/ldr_top_assertions.sv
// Concurrent checks on the ports of the drive range and power mode block
`timescale 1ns/1ps
module ldr_top_assertions #(
   parameter int OSC_DIV = 4,
   parameter int TICKS_PER_LINE = 2,
   parameter int LINES = 80
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [ldr_pkg::ADDR_W-1:0] regAddr,
   input wire logic [ldr_pkg::DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [ldr_pkg::DATA_W-1:0] regRdata,
   input wire logic [LINES-1:0] comTimeShare,
   input wire logic [ldr_pkg::LINE_W-1:0] activeLine,
   input wire logic outputsGround,
   input wire logic [2:0] boostMult,
   input wire logic [1:0] boost_factor_sel,
   input wire logic lcdPowerEn,
   input wire logic oscRunning,
   input wire logic frame_start_sync,
   input wire logic line_latch_sync,
   input wire logic shift_clock_sync
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   a_boost_map: assert property (
      $stable(boost_factor_sel) |-> boostMult == {1'b1, boost_factor_sel})
      else $error("boost multiplier does not follow the field");
   a_power_rd: assert property (
      regRd && regAddr == ldr_pkg::IDX_POWER && $stable(boost_factor_sel)
      ##1 $stable(boost_factor_sel) |-> regRdata[5:4] == boost_factor_sel)
      else $error("power word read disagrees with boost field");
   a_ground_mask: assert property (outputsGround |-> comTimeShare == '0)
      else $error("commons time-shared while grounded");
   a_halt_sync: assert property (
      outputsGround && $past(outputsGround)
      |-> !frame_start_sync && !line_latch_sync && activeLine == '0)
      else $error("sync outputs running while halted");
   // Scanner clears one cycle after the oscillator flag drops, so wait two cycles
   a_osc_frozen: assert property (
      !oscRunning && !$past(oscRunning) && !$past(oscRunning, 2) |-> $stable(shift_clock_sync))
      else $error("shift clock moves with oscillator stopped");
   a_standby_gnd: assert property (!oscRunning && !$past(oscRunning) |-> outputsGround)
      else $error("outputs not grounded with oscillator stopped");
   a_status_rd: assert property (
      regRd && regAddr == ldr_pkg::IDX_STATUS && $stable(oscRunning) && $stable(lcdPowerEn)
      ##1 $stable(oscRunning) && $stable(lcdPowerEn)
      |-> regRdata[0] == oscRunning && regRdata[2] == lcdPowerEn)
      else $error("status read disagrees with outputs");
   a_rd_idle: assert property (!$past(regRd) |-> regRdata == '0)
      else $error("read data present without a read");
   a_latch_pulse: assert property (line_latch_sync |=> !line_latch_sync)
      else $error("line latch longer than one cycle");
   a_frame_line: assert property (frame_start_sync |-> activeLine == '0)
      else $error("frame sync outside line zero");
endmodule

bind ldr_top ldr_top_assertions #(.OSC_DIV(OSC_DIV), .TICKS_PER_LINE(TICKS_PER_LINE),
   .LINES(LINES)) ldr_top_assertions_inst (.core_clk(core_clk), .rst_n(rst_n),
   .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
   .regRdata(regRdata), .comTimeShare(comTimeShare), .activeLine(activeLine),
   .outputsGround(outputsGround), .boostMult(boostMult),
   .boost_factor_sel(boost_factor_sel), .lcdPowerEn(lcdPowerEn), .oscRunning(oscRunning),
   .frame_start_sync(frame_start_sync), .line_latch_sync(line_latch_sync),
   .shift_clock_sync(shift_clock_sync));

//--- tb/ldr_host_model.sv
// Host processor model issuing register instructions
`timescale 1ns/1ps
module ldr_host_model (
   input wire logic core_clk,
   input wire logic [15:0] regRdata,
   output logic [2:0] regAddr,
   output logic [15:0] regWdata,
   output logic regWr,
   output logic regRd
);
   initial begin
      regAddr = 3'h0;
      regWdata = 16'h0;
      regWr = 1'b0;
      regRd = 1'b0;
   end

   // Released lines show the inverse so stale values never repeat the last ones driven
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
      regAddr <= ~a;
      regWdata <= ~d;
   endtask

   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      regAddr <= ~a;
      #1;
      d = regRdata;
   endtask

   // Oscillator is restarted and left to settle before standby is cleared
   task automatic standby_exit(input logic [15:0] pwr);
      wr(ldr_pkg::IDX_OSC_START, 16'h0);
      repeat (64) @(posedge core_clk);
      wr(ldr_pkg::IDX_POWER, pwr);
   endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the drive range and power mode block
`timescale 1ns/1ps
module tb_top;
   localparam int LN = 80;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] regAddr;
   logic [15:0] regWdata;
   logic regWr;
   logic regRd;
   logic [15:0] regRdata;
   logic [LN-1:0] comTimeShare;
   logic [6:0] activeLine;
   logic outputsGround;
   logic [2:0] boostMult;
   logic [1:0] boost_factor_sel;
   logic lcdPowerEn;
   logic oscRunning;
   logic frameSync;
   logic latchSync;
   logic shiftSync;
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;

   always #2.5 core_clk = ~core_clk;

   ldr_top #(.OSC_DIV(4), .TICKS_PER_LINE(2), .LINES(LN)) ldr_top_inst (
      .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .comTimeShare(comTimeShare),
      .activeLine(activeLine), .outputsGround(outputsGround), .boostMult(boostMult),
      .boost_factor_sel(boost_factor_sel), .lcdPowerEn(lcdPowerEn),
      .oscRunning(oscRunning), .frame_start_sync(frameSync),
      .line_latch_sync(latchSync), .shift_clock_sync(shiftSync));

   ldr_host_model host_inst (.core_clk(core_clk), .regRdata(regRdata), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd));

   function automatic logic [LN-1:0] span(input int s, input int e);
      span = '0;
      for (int i = s; i <= e; i++) span[i] = 1'b1;
   endfunction

   function automatic logic [15:0] rw(input logic [6:0] s, input logic [6:0] e);
      rw = {1'b0, e, 1'b0, s};
   endfunction

   function automatic logic [15:0] pw(input logic stb, input logic sleep_bit, input logic [1:0] amp,
                                      input logic [1:0] bst, input logic two,
                                      input logic [3:0] duty);
      pw = {4'h0, duty, 1'b0, two, bst, amp, sleep_bit, stb};
   endfunction

   task automatic give_verdict();
      if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk_mask(input logic [LN-1:0] got, input logic [LN-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t line mask %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic settle();
      repeat (3) @(posedge core_clk);
      #1;
   endtask

   function automatic logic [15:0] pins();
      pins = {13'h0, outputsGround, oscRunning, lcdPowerEn};
   endfunction

   task automatic t_reset();
      logic seen;
      seen = 1'b0;
      chk_mask(comTimeShare, span(0, 79));
      chk_val({13'h0, boostMult}, 16'h4, "reset boost");
      chk_val(pins(), 16'h3, "reset pins");
      repeat (24) begin
         @(negedge core_clk);
         seen = seen | latchSync;
      end
      chk_val({15'h0, seen}, 16'h1, "sync running");
   endtask

   task automatic t_boost();
      logic [15:0] d;
      for (int b = 0; b < 4; b++) begin
         host_inst.wr(ldr_pkg::IDX_POWER, pw(0, 0, 2'h1, b[1:0], 0, 4'h9));
         settle();
         chk_val({13'h0, boostMult}, 16'h4 + 16'(b), "boost");
         host_inst.rd(ldr_pkg::IDX_POWER, d);
         chk_val(d, pw(0, 0, 2'h1, b[1:0], 0, 4'h9), "power read");
      end
   endtask

   task automatic t_ranges();
      logic [15:0] d;
      host_inst.wr(ldr_pkg::IDX_RANGE1, rw(7'h05, 7'h14));
      host_inst.wr(ldr_pkg::IDX_RANGE2, rw(7'h1e, 7'h28));
      settle();
      chk_mask(comTimeShare, span(5, 20));
      host_inst.rd(ldr_pkg::IDX_RANGE2, d);
      chk_val(d, rw(7'h1e, 7'h28), "range read");
      host_inst.wr(ldr_pkg::IDX_POWER, pw(0, 0, 2'h1, 2'h0, 1, 4'h9));
      settle();
      chk_mask(comTimeShare, span(5, 20) | span(30, 40));
      host_inst.wr(ldr_pkg::IDX_POWER, pw(0, 0, 2'h1, 2'h0, 1, 4'h2));
      settle();
      chk_mask(comTimeShare, span(5, 20) | span(30, 37));
   endtask

   task automatic t_sleep();
      logic [15:0] d;
      host_inst.wr(ldr_pkg::IDX_POWER, pw(0, 1, 2'h0, 2'h0, 0, 4'h9));
      settle();
      chk_mask(comTimeShare, '0);
      chk_val(pins(), 16'h6, "sleep pins");
      repeat (20) @(posedge core_clk);
      host_inst.rd(ldr_pkg::IDX_STATUS, d);
      chk_val(d, 16'h0001, "sleep status");
      host_inst.wr(ldr_pkg::IDX_POWER, pw(0, 1, 2'h1, 2'h0, 0, 4'h9));
      settle();
      chk_val(pins(), 16'h7, "sleep amp on");
      host_inst.wr(ldr_pkg::IDX_POWER, pw(0, 0, 2'h1, 2'h0, 0, 4'h9));
      settle();
      chk_mask(comTimeShare, span(5, 20));
   endtask

   task automatic t_standby();
      logic [15:0] d;
      host_inst.wr(ldr_pkg::IDX_POWER, pw(1, 0, 2'h0, 2'h0, 0, 4'h9));
      settle();
      chk_val(pins(), 16'h4, "standby pins");
      chk_mask(comTimeShare, '0);
      host_inst.wr(ldr_pkg::IDX_RANGE1, rw(7'h00, 7'h4f));
      host_inst.wr(ldr_pkg::IDX_POWER, pw(1, 0, 2'h1, 2'h0, 0, 4'h9));
      settle();
      chk_val(pins(), 16'h4, "standby refuse");
      host_inst.standby_exit(pw(0, 0, 2'h1, 2'h0, 0, 4'h9));
      repeat (20) @(posedge core_clk);
      #1;
      chk_val(pins(), 16'h3, "standby exit");
      chk_mask(comTimeShare, span(5, 20));
      host_inst.wr(3'h7, 16'hffff);
      host_inst.rd(3'h5, d);
      chk_val(d, 16'h0, "unmapped read");
      host_inst.rd(ldr_pkg::IDX_RANGE1, d);
      chk_val(d, rw(7'h05, 7'h14), "range kept");
   endtask

   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      #1;
      t_reset();
      t_boost();
      t_ranges();
      t_sleep();
      t_standby();
      give_verdict();
   end

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         num_errors++;
         give_verdict();
      end
   end
endmodule
